// ==== verilog/ash_consts.svh ====
// constants of the serial host port: field positions, codes, reset values, timing
// assumes inclusion, before any module text, by every file of the port that uses its macros
`ifndef ASH_CONSTS_SVH
`define ASH_CONSTS_SVH

// clock and serial clock timing
`define ASH_CLK_PERIOD_NS    100
`define ASH_SCLK_DIV         8
`define ASH_SCLK_RISE_CNT    3'h3
`define ASH_SCLK_FALL_CNT    3'h7
`define ASH_EXT_SCLK_MAX_KHZ 5000

// instruction byte fields
`define ASH_INSTR_RD_BIT     7
`define ASH_INSTR_CNT_HI     6
`define ASH_INSTR_CNT_LO     5
`define ASH_INSTR_CODE_HI    3
`define ASH_INSTR_CODE_LO    0

// register codes: groups in the upper two bits of the code, and the full data memory code
`define ASH_GRP_CTRL         2'h0
`define ASH_GRP_SETUP_HI     2'h1
`define ASH_GRP_SETUP_LO     2'h2
`define ASH_GRP_RAM          2'h3
`define ASH_CODE_DATA_RAM    4'hc

// byte pointer masks and burst geometry
`define ASH_PTR_MASK_CTRL    4'h1
`define ASH_PTR_MASK_SETUP   4'h3
`define ASH_PTR_MASK_RAM     4'hf
`define ASH_PTR_FIRST        4'h0
`define ASH_PTR_LAST         4'hf
`define ASH_BURST_LEN        5'h10
`define ASH_ONE_BYTE         5'h01

// chip control word fields and reset value
`define ASH_CW_WIRE          0
`define ASH_CW_BITORD        1
`define ASH_CW_BYTEDIR       2
`define ASH_CW_NCH_HI        7
`define ASH_CW_NCH_LO        5
`define ASH_CW_RESET         16'h0000

// channel setup byte fields and reset value
`define ASH_SETUP_PAIR_HI    7
`define ASH_SETUP_PAIR_LO    5
`define ASH_SETUP_BIPOLAR    4
`define ASH_SETUP_MODE_HI    3
`define ASH_SETUP_MODE_LO    2
`define ASH_SETUP_GAIN_HI    1
`define ASH_SETUP_GAIN_LO    0
`define ASH_SETUP_RESET      8'h00
`define ASH_MODE_NORMAL      2'h0
`define ASH_GAIN_UNIT        4'h1

`endif

// ==== verilog/ash_pkg.sv ====
// types of the serial host port
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package ash_pkg;
  // port phases: instruction byte, then data bytes
  typedef enum logic {ash_instr, ash_data} ash_state_t;
  // channel operating modes
  typedef enum logic [1:0] {ash_normal, ash_cal_offset, ash_cal_pos, ash_cal_neg} ash_op_mode_t;
endpackage

`default_nettype wire

// ==== verilog/ash_cfg_mem.sv ====
// eight channel setup bytes, one per logical channel, all visible as registers
// assumes writes and calibration clears come from the port in the same clock domain
`include "ash_consts.svh"
`default_nettype none

module ash_cfg_mem
  import ash_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        we,
  input  wire logic [2:0]  waddr,
  input  wire logic [7:0]  wdata,
  input  wire logic        clr_mode,
  input  wire logic [2:0]  clr_addr,
  output wire logic [63:0] cfg_all
);

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_byte
      // host write outranks an auto-return in the same cycle
      wire logic hit_w = we && (waddr == 3'(gi));
      wire logic hit_c = clr_mode && (clr_addr == 3'(gi));
      logic [7:0] cfg_byte;
      // one register per byte keeps a single writer for every bit
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          cfg_byte <= `ASH_SETUP_RESET;
        end else if (hit_w) begin
          cfg_byte <= wdata;
        end else if (hit_c) begin
          cfg_byte[`ASH_SETUP_MODE_HI:`ASH_SETUP_MODE_LO] <= `ASH_MODE_NORMAL;
        end
      end
      assign cfg_all[gi*8 +: 8] = cfg_byte;
    end
  endgenerate

endmodule

`default_nettype wire

// ==== verilog/ash_serial_port.sv ====
// serial host port with chip control word, channel setup bytes and status pins
// assumes all pins synchronous to clk; pin levels resolved outside from the enables
`include "ash_consts.svh"
`default_nettype none

module ash_serial_port
  import ash_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         port_reset_n,
  input  wire logic         clock_mode,
  input  wire logic         cs_n,
  input  wire logic         sclk_in,
  output var  logic         sclk_out,
  output var  logic         sclk_oe,
  input  wire logic         sdio_in,
  output var  logic         sdio_out,
  output var  logic         sdio_oe,
  output var  logic         serial_out_pin,
  output var  logic         serial_out_pin_oe,
  input  wire logic         scan_start,
  input  wire logic         scan_complete,
  input  wire logic         cal_finish,
  input  wire logic [2:0]   cal_chan,
  input  wire logic [127:0] conv_results,
  input  wire logic [2:0]   seq_chan,
  output var  logic         scan_done_n,
  output var  logic         cal_active,
  output var  logic [15:0]  chip_control_word,
  output var  logic [2:0]   seq_input_pair,
  output var  logic         seq_bipolar,
  output var  logic [1:0]   seq_op_mode,
  output var  logic [3:0]   seq_gain
);

  // logical channel index of a setup byte: low block holds channels 1-4, highest byte first
  function automatic logic [2:0] chan_of(input logic [3:0] code, input logic [3:0] ptr);
    chan_of = {code[3:2] == `ASH_GRP_SETUP_HI, ~ptr[1:0]};
  endfunction

  // byte the port sends for a register code and byte pointer
  function automatic logic [7:0] fetch_byte(input logic [3:0] code, input logic [3:0] ptr,
                                            input logic [15:0] cw, input logic [63:0] cfg,
                                            input logic [127:0] conv);
    logic [2:0] ch;
    ch = chan_of(code, ptr);
    case (code[3:2])
      `ASH_GRP_CTRL: fetch_byte = cw[{ptr[0], 3'h0} +: 8];
      `ASH_GRP_SETUP_HI,
      `ASH_GRP_SETUP_LO: fetch_byte = cfg[{ch, 3'h0} +: 8];
      // calibration memories live elsewhere; they read as zero here
      default:       fetch_byte = (code == `ASH_CODE_DATA_RAM) ? conv[{ptr, 3'h0} +: 8] : 8'h00;
    endcase
  endfunction

  // byte pointer wraps inside the addressed register
  function automatic logic [3:0] ptr_mask(input logic [3:0] code);
    case (code[3:2])
      `ASH_GRP_CTRL: ptr_mask = `ASH_PTR_MASK_CTRL;
      `ASH_GRP_RAM:  ptr_mask = `ASH_PTR_MASK_RAM;
      default:       ptr_mask = `ASH_PTR_MASK_SETUP;
    endcase
  endfunction

  // mode field of one logical channel
  function automatic logic [1:0] mode_of(input logic [63:0] cfg, input logic [2:0] ch);
    mode_of = cfg[{ch, 3'(`ASH_SETUP_MODE_LO)} +: 2];
  endfunction

  ash_state_t  state;
  logic [2:0]  div_cnt;
  logic        sclk_prev;
  logic [2:0]  bit_cnt;
  logic [7:0]  rx_byte;
  logic [7:0]  instr;
  logic [4:0]  remain;
  logic [3:0]  ptr;
  logic [7:0]  tx_byte;
  logic [63:0] cfg_all;
  wire logic [7:0] cal_vec;

  // the serial machine and the pin drivers alone see the port reset
  wire logic port_rst_n = resetn & port_reset_n;

  // control word fields
  wire logic       wire3     = chip_control_word[`ASH_CW_WIRE];
  wire logic       lsb_first = chip_control_word[`ASH_CW_BITORD];
  wire logic       ascend    = chip_control_word[`ASH_CW_BYTEDIR];
  wire logic [2:0] nch_m1    = chip_control_word[`ASH_CW_NCH_HI:`ASH_CW_NCH_LO];

  // serial clock events; external edges seen by comparing with the last sample
  wire logic [2:0] next_div_cnt = div_cnt + 3'h1;
  wire logic self_rise = (div_cnt == `ASH_SCLK_RISE_CNT);
  wire logic self_fall = (div_cnt == `ASH_SCLK_FALL_CNT);
  wire logic ext_rise  = sclk_in & ~sclk_prev;
  wire logic ext_fall  = ~sclk_in & sclk_prev;
  // chip select high masks every edge, so the cycle simply waits
  wire logic rise = !cs_n && (clock_mode ? self_rise : ext_rise);
  wire logic fall = !cs_n && (clock_mode ? self_fall : ext_fall);

  // receive path, shift direction from the bit order bit
  wire logic [7:0] next_rx = lsb_first ? {sdio_in, rx_byte[7:1]} : {rx_byte[6:0], sdio_in};
  wire logic       byte_done = rise && (bit_cnt == 3'h7);

  // instruction decode of a freshly received instruction
  wire logic [3:0] new_code  = next_rx[`ASH_INSTR_CODE_HI:`ASH_INSTR_CODE_LO];
  wire logic       new_burst = (new_code[3:2] == `ASH_GRP_RAM);
  wire logic [4:0] new_count = new_burst ? `ASH_BURST_LEN
                             : {3'h0, next_rx[`ASH_INSTR_CNT_HI:`ASH_INSTR_CNT_LO]} + `ASH_ONE_BYTE;
  wire logic [3:0] new_ptr   = new_burst ? (ascend ? `ASH_PTR_FIRST : `ASH_PTR_LAST)
                             : {2'h0, next_rx[1:0]};

  // current cycle decode
  wire logic [3:0] code    = instr[`ASH_INSTR_CODE_HI:`ASH_INSTR_CODE_LO];
  wire logic       is_read = instr[`ASH_INSTR_RD_BIT];
  wire logic [3:0] nxt_ptr = (ascend ? ptr + 4'h1 : ptr - 4'h1) & ptr_mask(code);
  wire logic       in_data = (state == ash_data);
  wire logic       wr_byte = byte_done && in_data && !is_read;
  wire logic       last    = (remain == `ASH_ONE_BYTE);

  // write strobes; the data and calibration memories take no writes here
  wire logic       ctrl_we = wr_byte && (code[3:2] == `ASH_GRP_CTRL);
  wire logic       mem_we  = wr_byte && (code[3:2] == `ASH_GRP_SETUP_HI || code[3:2] == `ASH_GRP_SETUP_LO);
  wire logic [2:0] mem_waddr = chan_of(code, ptr);
  wire logic       burst_done = byte_done && in_data && is_read && last && (code == `ASH_CODE_DATA_RAM);

  // transmit bit for this position of the byte
  wire logic tx_bit = lsb_first ? tx_byte[bit_cnt] : tx_byte[3'h7 - bit_cnt];

  // calibration detection over the active channels only
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_cal
      assign cal_vec[gi] = (3'(gi) <= nch_m1) && (mode_of(cfg_all, 3'(gi)) != `ASH_MODE_NORMAL);
    end
  endgenerate
  wire logic cal_any = |cal_vec;

  // selected channel for the sequencer
  wire logic [7:0] seq_byte = cfg_all[{seq_chan, 3'h0} +: 8];

  ash_cfg_mem u_cfg (
    .clk      (clk),
    .resetn   (resetn),
    .we       (mem_we),
    .waddr    (mem_waddr),
    .wdata    (next_rx),
    .clr_mode (cal_finish),
    .clr_addr (cal_chan),
    .cfg_all  (cfg_all)
  );

  // free-running divider, so the self clock period never depends on traffic
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt  <= 3'h0;
      sclk_out <= 1'b0;
      sclk_oe  <= 1'b0;
    end else begin
      div_cnt  <= next_div_cnt;
      sclk_out <= next_div_cnt[2];
      sclk_oe  <= clock_mode && !cs_n;
    end
  end

  // serial state machine; port reset drops back to waiting for an instruction
  always_ff @(posedge clk or negedge port_rst_n) begin
    if (!port_rst_n) begin
      state     <= ash_instr;
      sclk_prev <= 1'b0;
      bit_cnt   <= 3'h0;
      rx_byte   <= 8'h00;
      instr     <= 8'h00;
      remain    <= 5'h00;
      ptr       <= 4'h0;
      tx_byte   <= 8'h00;
    end else begin
      sclk_prev <= sclk_in;
      if (rise) begin
        bit_cnt <= bit_cnt + 3'h1;
        rx_byte <= next_rx;
      end
      if (byte_done && !in_data) begin
        instr   <= next_rx;
        state   <= ash_data;
        remain  <= new_count;
        ptr     <= new_ptr;
        tx_byte <= fetch_byte(new_code, new_ptr, chip_control_word, cfg_all, conv_results);
      end else if (byte_done) begin
        remain  <= remain - 5'h1;
        ptr     <= nxt_ptr;
        tx_byte <= fetch_byte(code, nxt_ptr, chip_control_word, cfg_all, conv_results);
        if (last) begin
          state <= ash_instr;
        end
      end
    end
  end

  // pin drivers; data launched on the falling edge so the host samples it stable
  always_ff @(posedge clk or negedge port_rst_n) begin
    if (!port_rst_n) begin
      sdio_out          <= 1'b0;
      serial_out_pin    <= 1'b0;
      sdio_oe           <= 1'b0;
      serial_out_pin_oe <= 1'b0;
    end else begin
      if (fall) begin
        sdio_out       <= tx_bit;
        serial_out_pin <= tx_bit;
      end
      sdio_oe           <= !cs_n && in_data && is_read && !wire3;
      serial_out_pin_oe <= !cs_n && in_data && is_read && wire3;
    end
  end

  // control word survives port reset; only the chip reset clears it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chip_control_word <= `ASH_CW_RESET;
    end else if (ctrl_we) begin
      chip_control_word[{ptr[0], 3'h0} +: 8] <= next_rx;
    end
  end

  // status pins; a new scan result outranks a read finishing in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scan_done_n <= 1'b1;
      cal_active  <= 1'b0;
    end else begin
      if (scan_complete) begin
        scan_done_n <= 1'b0;
      end else if (burst_done) begin
        scan_done_n <= 1'b1;
      end
      if (scan_start) begin
        cal_active <= cal_any;
      end
    end
  end

  // per-channel decode handed to the sequencer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seq_input_pair <= 3'h0;
      seq_bipolar    <= 1'b0;
      seq_op_mode    <= `ASH_MODE_NORMAL;
      seq_gain       <= `ASH_GAIN_UNIT;
    end else begin
      seq_input_pair <= seq_byte[`ASH_SETUP_PAIR_HI:`ASH_SETUP_PAIR_LO];
      seq_bipolar    <= seq_byte[`ASH_SETUP_BIPOLAR];
      seq_op_mode    <= seq_byte[`ASH_SETUP_MODE_HI:`ASH_SETUP_MODE_LO];
      seq_gain       <= `ASH_GAIN_UNIT << seq_byte[`ASH_SETUP_GAIN_HI:`ASH_SETUP_GAIN_LO];
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_out_quiet;
    !wire3 && $past(!wire3) |-> !serial_out_pin_oe;
  endproperty
  a_out_quiet: assert property (p_out_quiet) else $error("output pin driven in two-wire mode");

  property p_sdio_read_two_wire;
    sdio_oe |-> $past(!wire3 && in_data && is_read);
  endproperty
  a_sdio_read_two_wire: assert property (p_sdio_read_two_wire) else $error("data pin driven outside two-wire read");

  property p_self_clock_period;
    $rose(sclk_out) |-> ##8 $rose(sclk_out);
  endproperty
  a_self_clock_period: assert property (p_self_clock_period) else $error("self clock period not eight cycles");

  property p_ext_clock_input;
    !clock_mode |=> !sclk_oe;
  endproperty
  a_ext_clock_input: assert property (p_ext_clock_input) else $error("clock pin driven in external mode");

  property p_cs_high_hiz;
    cs_n |=> !sdio_oe && !serial_out_pin_oe;
  endproperty
  a_cs_high_hiz: assert property (p_cs_high_hiz) else $error("data pin driven with chip select high");

  property p_cs_freeze;
    disable iff (!port_rst_n) cs_n |=> $stable(bit_cnt) && $stable(state) && $stable(remain);
  endproperty
  a_cs_freeze: assert property (p_cs_freeze) else $error("cycle moved while chip select high");

  property p_scan_done;
    scan_complete |=> !scan_done_n ##1 (!scan_done_n || $past(burst_done));
  endproperty
  a_scan_done: assert property (p_scan_done) else $error("scan done did not fall on new results");

  property p_read_clears_done;
    burst_done && !scan_complete |=> scan_done_n;
  endproperty
  a_read_clears_done: assert property (p_read_clears_done) else $error("scan done stayed low after full read");

  property p_cal_active;
    scan_start |=> cal_active == $past(cal_any) ##1 ($past(scan_start) || $stable(cal_active));
  endproperty
  a_cal_active: assert property (p_cal_active) else $error("cal active not held for the scan");

  property p_cal_return;
    cal_finish && !(mem_we && mem_waddr == cal_chan) |=> mode_of(cfg_all, $past(cal_chan)) == `ASH_MODE_NORMAL;
  endproperty
  a_cal_return: assert property (p_cal_return) else $error("channel mode not returned to normal");

  property p_port_reset;
    disable iff (!resetn) !port_reset_n |-> state == ash_instr && bit_cnt == 3'h0 && !sdio_oe;
  endproperty
  a_port_reset: assert property (p_port_reset) else $error("port reset did not abort the cycle");

  property p_two_phase;
    disable iff (!port_rst_n) byte_done && !in_data |=> in_data && remain != 5'h00;
  endproperty
  a_two_phase: assert property (p_two_phase) else $error("instruction not followed by data phase");

  property p_count_end;
    disable iff (!port_rst_n) byte_done && in_data && last |=> !in_data;
  endproperty
  a_count_end: assert property (p_count_end) else $error("port not back to standby after count");

  property p_data_mem_read_only;
    in_data && code == `ASH_CODE_DATA_RAM |-> !mem_we && !ctrl_we;
  endproperty
  a_data_mem_read_only: assert property (p_data_mem_read_only) else $error("write reached registers in data burst");

  c_read_cycle:  cover property (byte_done && in_data && is_read && last);
  c_write_cycle: cover property (byte_done && in_data && !is_read && last);
  c_burst_done:  cover property (burst_done);
  c_cs_suspend:  cover property (in_data && !cs_n ##1 cs_n [*4] ##1 !cs_n);

endmodule

`default_nettype wire

// ==== dv/ash_host_model.sv ====
// host model: mode 0 serial master with chip select, stepped on the bench clock
// assumes device pins are split in/out/enable; the data wires are resolved here
`default_nettype none

module ash_host_model (
  input  wire logic clk,
  input  wire logic sdio_out,
  input  wire logic sdio_oe,
  input  wire logic serial_out_pin,
  input  wire logic serial_out_pin_oe,
  output var  logic cs_n,
  output var  logic sclk,
  output var  logic sdio_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv, hd, last_io, last_so, so_line, pause_oe, seen_io, seen_so;

  // released wires toggle, so a stale level never passes for data
  assign so_line = serial_out_pin_oe ? serial_out_pin : ~last_so;
  assign sdio_in = sdio_oe ? sdio_out : (drv ? hd : ~last_io);

  // wire history and device drive seen within a frame
  always @(posedge clk) begin
    last_io <= sdio_in;
    last_so <= so_line;
    if (sdio_oe) seen_io <= 1'b1;
    if (serial_out_pin_oe) seen_so <= 1'b1;
  end

  initial begin
    {cs_n, sclk, drv, hd, last_io, last_so, pause_oe, seen_io, seen_so} = 9'h100;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  // select or release; clock parked low outside frames
  task automatic sel(input bit on);
    if (on) {seen_io, seen_so} = 2'h0;
    cs_n = !on;
    wt(2);
  endtask

  // one byte: launch while clock low, sample just before the rise
  task automatic xbyte(input logic [7:0] tx, input bit lsb, input bit tw, input bit wr, input int brk,
                       output logic [7:0] rx);
    int b;
    drv = wr;
    for (int i = 0; i < 8; i++) begin
      b = lsb ? i : 7 - i;
      if (i == brk) begin
        cs_n = 1'b1; // suspend mid-byte
        wt(4);
        pause_oe = sdio_oe | serial_out_pin_oe;
        cs_n = 1'b0;
        wt(2);
      end
      sclk = 1'b0;
      hd = tx[b];
      wt(3); // six clk a period keeps the clock well under 5 MHz
      rx[b] = tw ? so_line : sdio_in;
      sclk = 1'b1;
      wt(3);
    end
    sclk = 1'b0;
    drv = 1'b0;
  endtask
endmodule

`default_nettype wire

// ==== dv/ash_serial_port_tb.sv ====
// bench for the serial host port: host model, reference values, scenarios
// assumes the port, its package and the host model are compiled first
`include "ash_consts.svh"
`default_nettype none

module ash_serial_port_tb
  import ash_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic            clk, resetn, port_reset_n, clock_mode, scan_start, scan_complete, cal_finish, p;
  logic [2:0]      cal_chan, seq_chan;
  logic [127:0]    conv_results;
  wire logic       cs_n, h_sclk, sclk_in, sclk_out, sclk_oe, sdio_in, sdio_out, sdio_oe;
  wire logic       serial_out_pin, serial_out_pin_oe, scan_done_n, cal_active, seq_bipolar;
  wire logic [15:0] chip_control_word;
  wire logic [2:0] seq_input_pair;
  wire logic [1:0] seq_op_mode;
  wire logic [3:0] seq_gain;
  logic [7:0]      wb[16], rb[16], m_ch[8];
  logic [15:0]     m_cw;
  int              n_mismatch, samples_checked, hi, chg;

  // clock pin: the device drives it in self-clocking mode
  assign sclk_in = sclk_oe ? sclk_out : h_sclk;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ash_serial_port dut_u (.clk, .resetn, .port_reset_n, .clock_mode, .cs_n, .sclk_in, .sclk_out, .sclk_oe, .sdio_in,
    .sdio_out, .sdio_oe, .serial_out_pin, .serial_out_pin_oe, .scan_start, .scan_complete, .cal_finish, .cal_chan,
    .conv_results, .seq_chan, .scan_done_n, .cal_active, .chip_control_word, .seq_input_pair, .seq_bipolar,
    .seq_op_mode, .seq_gain);
  ash_host_model h (.clk, .sdio_out, .sdio_oe, .serial_out_pin, .serial_out_pin_oe, .cs_n, .sclk(h_sclk), .sdio_in);

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // host keeps framing itself: instruction, then exactly n bytes
  task automatic frame(input logic [7:0] ins, input int n, input bit rd, input int brk);
    logic [7:0] r;
    h.sel(1'b1);
    h.xbyte(ins, m_cw[1], m_cw[0], 1'b1, -1, r);
    for (int k = 0; k < n; k++)
      h.xbyte(wb[k], m_cw[1], m_cw[0], !rd, k == 1 ? brk : -1, rb[k]);
    h.sel(1'b0);
  endtask

  // decoded fields of every logical channel against the model
  task automatic chk_ch;
    for (int i = 0; i < 8; i++) begin
      seq_chan = 3'(i);
      repeat (2) @(negedge clk);
      check("pair", seq_input_pair, m_ch[i][7:5]);
      check("bipolar", seq_bipolar, m_ch[i][4]);
      check("mode", seq_op_mode, m_ch[i][3:2]);
      check("gain", seq_gain, 4'h1 << m_ch[i][1:0]);
    end
  endtask

  task automatic chk_rd(input int base, input int step);
    for (int k = 0; k < 4; k++)
      check("read byte", rb[k], m_ch[base + step * k]);
  endtask

  task automatic start_scan;
    scan_start = 1'b1;
    @(negedge clk);
    scan_start = 1'b0;
    @(negedge clk);
  endtask

  // scenarios, inputs changed on the falling edge
  initial begin
    void'($urandom(32'h9647));
    {resetn, port_reset_n, clock_mode, scan_start, scan_complete, cal_finish} = 6'h10;
    {cal_chan, seq_chan} = 6'h00;
    conv_results = {$urandom, $urandom, $urandom, $urandom};
    m_cw = `ASH_CW_RESET;
    for (int i = 0; i < 8; i++) m_ch[i] = `ASH_SETUP_RESET;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    check("scan_done_n", scan_done_n, 1'b1);
    check("cal_active", cal_active, 1'b0);
    check("sclk_oe", sclk_oe, 1'b0);
    chk_ch;
    $display("test reset done");
    // both setup blocks, descending from byte 3; every pair, mode and gain code
    for (int g = 0; g < 2; g++) begin
      for (int k = 0; k < 4; k++) begin
        wb[k] = {3'(4 * g + k) ^ 3'h5, 1'($urandom), 2'(k), 2'(k)};
        m_ch[4 * g + k] = wb[k];
      end
      frame(g ? 8'h67 : 8'h6b, 4, 1'b0, -1);
    end
    chk_ch;
    frame(8'heb, 4, 1'b1, 1); // suspended in the second byte
    chk_rd(0, 1);
    check("paused oe", h.pause_oe, 1'b0);
    check("out pin driven", h.seen_so, 1'b0);
    check("sdio driven", h.seen_io, 1'b1);
    $display("test setup bytes done");
    // control write instruction, then port reset: its data byte must not land
    h.sel(1'b1);
    h.xbyte(8'h00, 1'b0, 1'b0, 1'b1, -1, rb[0]);
    port_reset_n = 1'b0;
    repeat (2) @(negedge clk);
    port_reset_n = 1'b1;
    frame(8'h80, 1, 1'b1, -1);
    check("cw byte0", rb[0], 8'h00);
    check("control word", chip_control_word, m_cw);
    chk_ch;
    $display("test port reset done");
    wb[0] = 8'h27; // two channels, ascending, lsb first, three-wire
    frame(8'h00, 1, 1'b0, -1);
    m_cw = 16'h0027;
    check("control word", chip_control_word, m_cw);
    frame(8'he8, 4, 1'b1, -1); // ascending from the least significant byte
    chk_rd(3, -1);
    check("sdio driven", h.seen_io, 1'b0);
    check("out pin driven", h.seen_so, 1'b1);
    $display("test three-wire done");
    // second channel calibrates; third does too but lies beyond the count
    start_scan;
    check("cal_active", cal_active, 1'b1);
    cal_chan = 3'h1;
    cal_finish = 1'b1;
    @(negedge clk);
    cal_finish = 1'b0;
    m_ch[1][3:2] = `ASH_MODE_NORMAL;
    chk_ch;
    start_scan;
    check("cal_active", cal_active, 1'b0);
    $display("test calibration done");
    scan_complete = 1'b1;
    @(negedge clk);
    scan_complete = 1'b0;
    @(negedge clk);
    check("scan_done_n", scan_done_n, 1'b0);
    frame(8'h8c, 16, 1'b1, -1); // burst length ignores the count bits
    for (int k = 0; k < 16; k++)
      check("data byte", rb[k], conv_results[8 * k +: 8]);
    check("scan_done_n", scan_done_n, 1'b1);
    $display("test data burst done");
    // self clock: one eighth of clk, half high, driven only while selected
    clock_mode = 1'b1;
    h.sel(1'b1);
    hi = 0;
    chg = 0;
    p = sclk_out;
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      hi += int'(sclk_out);
      if (sclk_out !== p) chg++;
      p = sclk_out;
    end
    check("sclk high", 16'(hi), 16'h8);
    check("sclk edges", 16'(chg), 16'h4);
    check("sclk_oe", sclk_oe, 1'b1);
    h.sel(1'b0);
    check("sclk_oe", sclk_oe, 1'b0);
    $display("test self clock done");
    results;
  end

  // hang guard, far beyond the few thousand cycles the tests take
  initial begin
    #2_000_000;
    n_mismatch++;
    results;
  end
endmodule

`default_nettype wire
